// *** core/pgl_core.sv ***
// Purpose: pci board glue, interrupt routing and status
// Assumes: apb slave, zero wait states, irq, board and wake inputs asynchronous
// Notes:   wired-or nets are modelled as and of active-low pins
// What this block does
// - slot pins rotate one line per slot
// - pci irq lines active low, level sensed
// - net controller irq on general line 2
// - bridge bus error on general line 0
// - bridge summary irq on general line 1
// - controller disk irq on general line 3
// - multi-io irq pair on lines 4, 5
// - software bit enables backup arbiter
// - board modification code readable by software
// - artwork revision readable, first reads zero
// - bus clock fixed 33 mhz
// - pci accesses single data cycle only
// - one bus reset resets slots and net
// - net wake reaches multi-io power-up
`timescale 1ns/1ps
module pgl_core
	import pgl_pkg::*;
#(
	parameter int AW = 12
) (
	input  wire logic          mclk_i,
	input  wire logic          arst_n_i,
	// apb slave
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [AW-1:0] paddr_i,
	input  wire logic [31:0]   pwdata_i,
	output logic      [31:0]   prdata_o,
	output logic               pready_o,
	output logic               pslverr_o,
	// interrupt and board inputs
	input  wire pgl_gin_t      gin_src_i,
	input  wire pgl_board_t    board_i,
	input  wire logic [15:0]   slot_pin_n_i,
	input  wire logic [3:0]    bridge_pin_n_i,
	output logic      [3:0]    pci_irq_lines_n_o,
	// configuration selects
	input  wire logic [31:0]   ad_i,
	output logic      [5:0]    idsel_o,
	// cpu access gate
	input  wire logic          cpu_req_i,
	input  wire logic          cpu_burst_i,
	output logic               cpu_gnt_o,
	// arbiter, clock, reset, wake
	output logic               backup_arbiter_enable_o,
	output logic               pci_clk_o,
	input  wire logic          bus_reset_n_i,
	output logic      [3:0]    slot_reset_n_o,
	output logic               net_reset_n_o,
	input  wire logic          net_wake_i,
	output logic               remote_wake_out_o
);
	localparam int SW = 18;

	logic [3:0]    rot_n [4];
	logic [SW-1:0] raw;
	logic [SW-1:0] syn;
	logic [5:0]    gin_q;
	logic [3:0]    pirq_q;
	logic [3:0]    mod_q;
	logic [2:0]    rev_q;
	logic          wake_q;
	logic          arb_ff;
	logic [1:0]    stat_ff;
	logic [1:0]    nxt_stat;
	logic [31:0]   rdata_ff;
	logic [31:0]   nxt_rdata;
	logic [6:0]    acc_ff;
	logic [7:0]    nxt_acc;
	logic          clk_ff;
	logic          setup;
	logic          wr;
	logic          hit;
	logic          burst_ev;

	// each slot gets its own rotation, slot index 0 to 3
	for (genvar s = 0; s < 4; s++)
	begin : g_slot
		pgl_irq_rot #(
			.SLOT (s)
		) u_rot (
			.pin_n_i  (slot_pin_n_i[4*s +: 4]),
			.line_n_o (rot_n[s])
		);
	end

	// wired-or of all drivers, same net also goes to the bridge
	assign pci_irq_lines_n_o = rot_n[0] & rot_n[1] & rot_n[2]
		& rot_n[3] & bridge_pin_n_i;

	// select lines taken straight from the address bus
	assign idsel_o[0] = ad_i[PGL_AD_SLOT1];
	assign idsel_o[1] = ad_i[PGL_AD_SLOT2];
	assign idsel_o[2] = ad_i[PGL_AD_SLOT3];
	assign idsel_o[3] = ad_i[PGL_AD_NET];
	assign idsel_o[4] = ad_i[PGL_AD_BRIDGE];
	assign idsel_o[5] = ad_i[PGL_AD_SLOT4];

	// reset fans out unclocked so it works with the clock stopped
	assign slot_reset_n_o = {4{bus_reset_n_i}};
	assign net_reset_n_o  = bus_reset_n_i;

	// wake runs on standby power, so no clocked path
	assign remote_wake_out_o = net_wake_i;

	// every asynchronous level goes through one bank
	assign raw = {net_wake_i, board_i, pci_irq_lines_n_o, gin_src_i};

	pgl_sync #(
		.W (SW)
	) u_sync (
		.mclk_i   (mclk_i),
		.arst_n_i (arst_n_i),
		.d_i      (raw),
		.q_o      (syn)
	);

	assign gin_q  = syn[5:0];
	assign pirq_q = syn[9:6];
	assign mod_q  = syn[13:10];
	assign rev_q  = syn[16:14];
	assign wake_q = syn[17];

	// bursts are refused; single cycles pass
	assign cpu_gnt_o = cpu_req_i & ~cpu_burst_i;
	assign burst_ev  = cpu_req_i & cpu_burst_i;

	// apb decode
	assign setup = psel_i & ~penable_i;
	assign wr    = psel_i & penable_i & pwrite_i;
	always_comb
	begin
		case (paddr_i[11:0])
			PGL_OFF_CTRL, PGL_OFF_GIN, PGL_OFF_PIRQ,
			PGL_OFF_BRIDGE, PGL_OFF_STAT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit;

	// read data prepared in setup, shown in access
	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (setup)
		begin
			nxt_rdata = 32'h0000_0000;
			case (paddr_i[11:0])
				PGL_OFF_CTRL:
					nxt_rdata[PGL_CTRL_ARB_BIT] = arb_ff;
				PGL_OFF_GIN:
					nxt_rdata[5:0] = gin_q;
				PGL_OFF_PIRQ:
					nxt_rdata[3:0] = pirq_q;
				PGL_OFF_BRIDGE:
				begin
					nxt_rdata[PGL_MOD_LSB +: 4] = mod_q;
					nxt_rdata[PGL_REV_LSB +: 3] = rev_q;
				end
				PGL_OFF_STAT:
					nxt_rdata[1:0] = stat_ff;
				default:
					nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rdata_ff <= 32'h0000_0000;
		else
			rdata_ff <= nxt_rdata;
	end
	assign prdata_o = rdata_ff;

	// arbiter enable, software owned
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			arb_ff <= PGL_ARB_RST;
		else if (wr && paddr_i[11:0] == PGL_OFF_CTRL)
			arb_ff <= pwdata_i[PGL_CTRL_ARB_BIT];
	end
	assign backup_arbiter_enable_o = arb_ff;

	// sticky status, write one clears, a new event beats the clear
	always_comb
	begin
		nxt_stat = stat_ff;
		if (wr && paddr_i[11:0] == PGL_OFF_STAT)
			nxt_stat = stat_ff & ~pwdata_i[1:0];
		if (burst_ev)
			nxt_stat[PGL_STAT_BURST] = 1'b1;
		if (wake_q)
			nxt_stat[PGL_STAT_WAKE] = 1'b1;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			stat_ff <= PGL_STAT_RST;
		else
			stat_ff <= nxt_stat;
	end

	// phase accumulator: 66 half-periods per 125 cycles, i.e. 33 mhz
	// on average; edges jitter by one system cycle, a trade for no pll
	assign nxt_acc = 8'(acc_ff) + 8'(PGL_ACC_STEP);
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			acc_ff <= 7'h00;
			clk_ff <= 1'b0;
		end
		else if (nxt_acc >= 8'(PGL_ACC_MOD))
		begin
			acc_ff <= 7'(nxt_acc - 8'(PGL_ACC_MOD));
			clk_ff <= ~clk_ff;
		end
		else
			acc_ff <= nxt_acc[6:0];
	end
	assign pci_clk_o = clk_ff;

	// helper: toggles seen in one accumulator period
	logic [7:0] per_ff;
	logic [6:0] tog_ff;
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			per_ff <= 8'h00;
			tog_ff <= 7'h00;
		end
		else if (per_ff == 8'(PGL_ACC_MOD - 1))
		begin
			per_ff <= 8'h00;
			tog_ff <= 7'h00;
		end
		else
		begin
			per_ff <= per_ff + 8'h01;
			tog_ff <= tog_ff + 7'(nxt_acc >= 8'(PGL_ACC_MOD));
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);

	property p_idsel;
		ad_i[PGL_AD_NET] == idsel_o[3] && ad_i[PGL_AD_SLOT4] == idsel_o[5];
	endproperty
	a_idsel: assert property (p_idsel) else $error("select line mismatch");

	property p_rot;
		!slot_pin_n_i[4] |-> !pci_irq_lines_n_o[1];
	endproperty
	a_rot: assert property (p_rot) else $error("slot two pin a not on line 1");

	property p_level;
		(!pci_irq_lines_n_o[0])[*3] |-> !pirq_q[0];
	endproperty
	a_level: assert property (p_level) else $error("held irq level not seen");

	property p_net;
		(!gin_src_i.net_ctrl_irq_n)[*3] |-> !gin_q[2];
	endproperty
	a_net: assert property (p_net) else $error("net irq missing on line 2");

	property p_buserr;
		gin_src_i.bridge_bus_error_flag[*3] |-> gin_q[0];
	endproperty
	a_buserr: assert property (p_buserr) else $error("bus error missing on line 0");

	// remaining general lines and board identity: a steady source shows up two edges later
	property p_summary;
		$stable(gin_src_i.bridge_summary_irq)[*2] |-> gin_q[1] == gin_src_i.bridge_summary_irq;
	endproperty
	a_summary: assert property (p_summary) else $error("summary irq missing on line 1");

	property p_disk;
		$stable(gin_src_i.controller_disk_irq)[*2] |-> gin_q[3] == gin_src_i.controller_disk_irq;
	endproperty
	a_disk: assert property (p_disk) else $error("disk irq missing on line 3");

	property p_pair;
		$stable(gin_src_i.multi_io_irq_pair)[*2] |-> gin_q[5:4] == gin_src_i.multi_io_irq_pair;
	endproperty
	a_pair: assert property (p_pair) else $error("multi-io pair missing on lines 4 and 5");

	property p_board;
		$stable(board_i)[*2] |-> {rev_q, mod_q} == board_i;
	endproperty
	a_board: assert property (p_board) else $error("board identity not readable");

	property p_sync;
		##2 1 |-> gin_q == $past(gin_src_i, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("sync latency not two");

	property p_arb;
		wr && paddr_i[11:0] == PGL_OFF_CTRL |=>
			backup_arbiter_enable_o == $past(pwdata_i[PGL_CTRL_ARB_BIT]);
	endproperty
	a_arb: assert property (p_arb) else $error("arbiter enable not written");

	property p_burst;
		burst_ev |-> !cpu_gnt_o ##1 stat_ff[PGL_STAT_BURST];
	endproperty
	a_burst: assert property (p_burst) else $error("burst not refused");

	property p_clk;
		per_ff == 8'(PGL_ACC_MOD - 1) |-> tog_ff inside {7'h41, 7'h42};
	endproperty
	a_clk: assert property (p_clk) else $error("bus clock rate off");

	property p_rst;
		!bus_reset_n_i |-> slot_reset_n_o == 4'h0 && !net_reset_n_o;
	endproperty
	a_rst: assert property (p_rst) else $error("bus reset not fanned out");

	property p_wake;
		net_wake_i |-> remote_wake_out_o ##3 stat_ff[PGL_STAT_WAKE];
	endproperty
	a_wake: assert property (p_wake) else $error("wake not passed");

	c_cfg:   cover property (idsel_o[3] && psel_i);
	c_burst: cover property (burst_ev);
	c_clr:   cover property (wr && paddr_i[11:0] == PGL_OFF_STAT && stat_ff != 2'h0);
	c_wake:  cover property (stat_ff[PGL_STAT_WAKE]);
	c_slot4: cover property (!slot_pin_n_i[12] && !pci_irq_lines_n_o[3]);
endmodule

// *** core/pgl_irq_rot.sv ***
// Purpose: per-slot rotation of interrupt pins onto shared lines
// Assumes: pins and lines are active low
// Notes:   pin a of slot n lands on line n
`timescale 1ns/1ps
module pgl_irq_rot #(
	parameter int SLOT = 0
) (
	input  wire logic [3:0] pin_n_i,
	output logic      [3:0] line_n_o
);
	// line index is pin plus slot, modulo four
	always_comb
	begin
		for (int p = 0; p < 4; p++)
			line_n_o[(p + SLOT) % 4] = pin_n_i[p];
	end
endmodule

// *** core/pgl_pkg.sv ***
// Purpose: shared constants and types of the pci board glue
// Assumes: apb with 32-bit data, one word per register
// Notes:   offsets are byte addresses
package pgl_pkg;
	// register map
	localparam logic [11:0] PGL_OFF_CTRL   = 12'h000;
	localparam logic [11:0] PGL_OFF_GIN    = 12'h004;
	localparam logic [11:0] PGL_OFF_PIRQ   = 12'h008;
	localparam logic [11:0] PGL_OFF_BRIDGE = 12'h00c;
	localparam logic [11:0] PGL_OFF_STAT   = 12'h010;
	// field positions
	localparam int PGL_CTRL_ARB_BIT  = 0;
	localparam int PGL_STAT_BURST    = 0;
	localparam int PGL_STAT_WAKE     = 1;
	localparam int PGL_MOD_LSB       = 13;
	localparam int PGL_REV_LSB       = 17;
	// reset values
	localparam logic       PGL_ARB_RST  = 1'b0;
	localparam logic [1:0] PGL_STAT_RST = 2'h0;
	// address lines used as configuration selects
	localparam int PGL_AD_SLOT1  = 24;
	localparam int PGL_AD_SLOT2  = 25;
	localparam int PGL_AD_SLOT3  = 26;
	localparam int PGL_AD_NET    = 27;
	localparam int PGL_AD_BRIDGE = 28;
	localparam int PGL_AD_SLOT4  = 29;
	// bus clock synthesis from the system clock
	localparam int PGL_SYS_MHZ  = 125;
	localparam int PGL_PCI_MHZ  = 33;
	localparam int PGL_ACC_STEP = 2 * PGL_PCI_MHZ;
	localparam int PGL_ACC_MOD  = PGL_SYS_MHZ;

	// interrupt and status sources bound for the general input lines
	typedef struct packed {
		logic [1:0] multi_io_irq_pair;
		logic       controller_disk_irq;
		logic       net_ctrl_irq_n;
		logic       bridge_summary_irq;
		logic       bridge_bus_error_flag;
	} pgl_gin_t;

	// board identity inputs read through the bridge
	typedef struct packed {
		logic [2:0] board_artwork_rev;
		logic [3:0] board_mod_state;
	} pgl_board_t;
endpackage

// *** core/pgl_sync.sv ***
// Purpose: two-stage synchroniser bank
// Assumes: bits are independent levels
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module pgl_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk_i,
	input  wire logic         arst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// two flops so metastability never reaches software
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_ff <= '0;
			q_ff    <= '0;
		end
		else
		begin
			meta_ff <= d_i;
			q_ff    <= meta_ff;
		end
	end

	assign q_o = q_ff;
endmodule

// *** test/pgl_card_model.sv ***
// Purpose: behavioural pci card sitting in one expansion slot
// Assumes: interrupt pins are open-drain with board pull-ups
// Notes:   a single-function card only ever uses pin a
`timescale 1ns/1ps
module pgl_card_model (
	input  wire logic       rst_n_i,
	input  wire logic       multi_i,
	input  wire logic [3:0] req_i,
	output logic      [3:0] pin_n_o
);
	// cards here never master the bus, so burst sizing stays with real masters
	// a card in reset lets go, so the pins float high
	always_comb
	begin
		if (!rst_n_i)
			pin_n_o = 4'hf;
		else if (multi_i)
			pin_n_o = ~req_i;
		else
			pin_n_o = {3'b111, ~req_i[0]};
	end
endmodule

// *** test/pgl_core_bench.sv ***
// Purpose: self-checking bench of the pci board glue
// Assumes: four card models in the slots, bench is the apb master
// Notes:   expected read data is queued and matched by a monitor
`timescale 1ns/1ps
module pgl_core_bench import pgl_pkg::*;;
	logic clk, rst_n, psel, pen, pwr, req, burst, bres_n, wake, prev;
	logic [11:0] paddr;
	logic [31:0] pwdata, ad, rnd, prdata;
	logic [3:0] creq [4];
	logic [3:0] multi, bpin, lines, srst_n;
	logic [5:0] idsel;
	logic [15:0] pins;
	logic [32:0] exp_q [$];
	pgl_gin_t gin;
	pgl_board_t board;
	logic pready, pslverr, gnt, arb, pclk, nrst_n, remote_wake_out;
	int error_cnt, checked, n;

	pgl_core uut (.mclk_i(clk), .arst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.gin_src_i(gin), .board_i(board), .slot_pin_n_i(pins), .bridge_pin_n_i(bpin),
		.pci_irq_lines_n_o(lines), .ad_i(ad), .idsel_o(idsel), .cpu_req_i(req), .cpu_burst_i(burst),
		.cpu_gnt_o(gnt), .backup_arbiter_enable_o(arb), .pci_clk_o(pclk), .bus_reset_n_i(bres_n),
		.slot_reset_n_o(srst_n), .net_reset_n_o(nrst_n), .net_wake_i(wake), .remote_wake_out_o(remote_wake_out));

	// one card per slot, each held in reset by its own slot reset
	for (genvar g = 0; g < 4; g++)
	begin : card
		pgl_card_model m (.rst_n_i(srst_n[g]), .multi_i(multi[g]), .req_i(creq[g]), .pin_n_o(pins[4*g +: 4]));
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask

	// reads queue {slverr, data}; held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			exp_q.push_back(e);
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// clock and watchdog
	always #4 clk = ~clk;
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end

	// monitor matches each finished read against the oldest note
	always @(posedge clk)
		if (psel && pen && pready === 1'b1 && !pwr)
			chk("apb_read", exp_q.pop_front(), {pslverr, prdata});

	// main sequence
	initial
	begin
		{clk, rst_n, psel, pen, pwr, req, burst, wake, prev, paddr, pwdata, ad, gin, board, multi} = '0;
		{bres_n, bpin} = 5'h1f;
		creq = '{default: 4'h0};
		rnd = 32'h25e0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, PGL_OFF_CTRL, 0, 33'h0);
		apb(1, PGL_OFF_CTRL, 32'h1, 0);
		apb(0, PGL_OFF_CTRL, 0, 33'h1);
		apb(0, PGL_OFF_BRIDGE, 0, 33'h0);
		chk("arb_en", 1, arb);
		apb(0, 12'h0f0, 0, 33'h100000000);
		for (int i = 0; i < 6; i++)
		begin
			rnd = lfsr(rnd);
			@(posedge clk) ad <= (32'h1 << (24 + i)) | (rnd & 32'hff);
			@(negedge clk) chk("idsel", 6'h1 << i, idsel);
		end
		// multi-function pins of every slot, then the bridge
		@(posedge clk) multi <= 4'hf;
		for (int s = 0; s < 5; s++)
			for (int p = 0; p < 4; p++)
			begin
				@(posedge clk);
				foreach (creq[k]) creq[k] <= (k == s) ? 4'h1 << p : 4'h0;
				bpin <= (s == 4) ? ~(4'h1 << p) : 4'hf;
				@(negedge clk) chk("lines", ~(4'h1 << ((s == 4) ? p : (p + s) % 4)) & 4'hf, lines);
			end
		// single-function cards land on distinct lines
		@(posedge clk) multi <= 4'h0;
		bpin <= 4'hf;
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clk);
			foreach (creq[k]) creq[k] <= (k == s) ? 4'hf : 4'h0;
			repeat (3) @(posedge clk);
			chk("lines", ~(4'h1 << s) & 4'hf, lines);
			apb(0, PGL_OFF_PIRQ, 0, ~(4'h1 << s) & 4'hf);
		end
		rnd = lfsr(rnd);
		@(posedge clk) gin <= pgl_gin_t'(rnd[5:0]);
		apb(0, PGL_OFF_GIN, 0, 33'h0);
		apb(0, PGL_OFF_GIN, 0, rnd[5:0]);
		board <= pgl_board_t'(rnd[12:6]);
		repeat (3) @(posedge clk);
		apb(0, PGL_OFF_BRIDGE, 0, 33'(rnd[12:6]) << PGL_MOD_LSB);
		@(posedge clk) {req, burst} <= 2'b11; // a burst the cpu must not send
		@(negedge clk) chk("gnt", 0, gnt);
		@(posedge clk) burst <= 1'b0;
		@(negedge clk) chk("gnt", 1, gnt);
		@(posedge clk) req <= 1'b0;
		apb(0, PGL_OFF_STAT, 0, 33'h1);
		apb(1, PGL_OFF_STAT, 32'h1, 0);
		@(posedge clk) wake <= 1'b1;
		@(negedge clk) chk("wake_out", 1, remote_wake_out);
		repeat (4) @(posedge clk);
		wake <= 1'b0;
		apb(0, PGL_OFF_STAT, 0, 33'h2);
		@(posedge clk) bres_n <= 1'b0;
		multi <= 4'hf;
		creq <= '{default: 4'hf};
		@(negedge clk) chk("resets", 5'h0, {srst_n, nrst_n});
		chk("lines", 4'hf, lines);
		@(posedge clk) bres_n <= 1'b1;
		// bus clock: 330 rises expected over 1250 system cycles
		repeat (1250)
		begin
			@(posedge clk);
			if (pclk && !prev)
				n++;
			prev = pclk;
		end
		chk("pci_clk", 1, n >= 329 && n <= 331);
		print_verdict();
	end
endmodule
